// file: shc_regs.vh
// Constants shared by the SPI host command port and its helpers.
`ifndef SHC_REGS_VH
`define SHC_REGS_VH

// Instruction codes understood by the command engine.
`define SHC_OPC_WRITE 8'h00
`define SHC_OPC_OR 8'h01
`define SHC_OPC_AND 8'h02
`define SHC_OPC_READ 8'h04

// Frame lengths in bytes, opcode included.
`define SHC_LEN_WRITE 9'h006
`define SHC_LEN_READ 9'h002
`define SHC_LEN_MAX 9'h105
`define SHC_CNT_SAT 9'h1FF

// Status flag positions.
`define SHC_NFLAGS 3
`define SHC_FLAG_FAULT 0
`define SHC_FLAG_OVF 1
`define SHC_FLAG_DONE 2

// Register bank and byte FIFO geometry.
`define SHC_REG_AW 6
`define SHC_REG_DW 32
`define SHC_FIFO_W 9
`define SHC_FIFO_D 16
`define SHC_FIFO_AW 4
`define SHC_MARK_BIT 8

`endif

// file: shc_fifo.v
// Byte FIFO between the serial front end and the command engine.
`default_nettype none

module shc_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock_in,
  input wire sys_rst_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  localparam [AW:0] FULL = DEPTH[AW:0];

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready_out = (count_reg != FULL);
  assign out_valid_out = (count_reg != {(AW+1){1'b0}});
  assign out_data_out = mem_reg[rptr_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always @(posedge clock_in)
  begin
    if (push)
    begin
      mem_reg[wptr_reg] <= in_data_in;
    end
  end

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop)
      begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (push & ~pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop & ~push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // shc_fifo

`default_nettype wire

// file: shc_regbank.v
// Bank of 32-bit registers with a registered read port.
`default_nettype none

module shc_regbank #(
  parameter AW = 6,
  parameter DW = 32
) (
  input wire clock_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [AW-1:0] addr_in,
  input wire [DW-1:0] wr_data_in,
  output wire [DW-1:0] rd_data_out
);

  reg [DW-1:0] mem_reg [0:(1<<AW)-1];
  reg [DW-1:0] rd_data_reg;

  assign rd_data_out = rd_data_reg;

  always @(posedge clock_in)
  begin
    if (wr_en_in)
    begin
      mem_reg[addr_in] <= wr_data_in;
    end
    if (rd_en_in)
    begin
      rd_data_reg <= mem_reg[addr_in];
    end
  end

endmodule // shc_regbank

`default_nettype wire

// file: shc_host_port.v
// SPI slave host command port with BUSY handshake and interrupt line.
// What this block does
// - Serial port runs only in mode 0 within the maximum bit rate.
// - Each frame carries data in one direction only.
// - Data-out pin floats while slave select is high; pull-up optional.
// - Every byte travels most significant bit first.
// - BUSY is high during reception and processing, low when ready.
// - Invalid parameter sets the fault flag and raises the interrupt.
// - Writes take one frame; reads take instruction and response frames.
// - Opcode byte first, then at least one payload byte.
// - Four-byte values travel least significant byte first.
// - At most 260 parameter bytes follow the opcode.
// - Responses are bare payload bytes without any header.
// - Unmet preconditions raise the interrupt and record the cause.
// - Stores decouple host transfer timing from the command engine.
// - Opcode 0x00 writes a register; 0x04 returns one next frame.
// - Opcode 0x01 ORs a mask in; 0x02 ANDs a mask in.
// - Enabled flags drive the interrupt; clear by write or by read.
`default_nettype none
`include "shc_regs.vh"

module shc_host_port (
  input wire clock_in,
  input wire sys_rst_in,
  input wire spi_sck_in,
  input wire spi_nss_n_in,
  input wire spi_mosi_in,
  output wire spi_miso_out,
  output wire spi_miso_oe_out,
  input wire miso_pullup_cfg_in,
  input wire clear_on_read_cfg_in,
  input wire irq_active_high_cfg_in,
  input wire [`SHC_NFLAGS-1:0] irq_enable_in,
  input wire [`SHC_NFLAGS-1:0] irq_clear_in,
  input wire status_read_in,
  output wire miso_pullup_en_out,
  output wire busy_out,
  output wire irq_out,
  output wire [`SHC_NFLAGS-1:0] irq_status_out
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_EXEC = 4'h2;
  localparam [3:0] ST_RD = 4'h4;
  localparam [3:0] ST_SPARE = 4'h8;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg sck_s1_reg, sck_s2_reg, sck_s3_reg;
  reg nss_s1_reg, nss_s2_reg, nss_s3_reg;
  reg mosi_s1_reg, mosi_s2_reg;

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      nss_s1_reg <= 1'b1;
      nss_s2_reg <= 1'b1;
      nss_s3_reg <= 1'b1;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
    end
    else
    begin
      sck_s1_reg <= spi_sck_in;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      nss_s1_reg <= spi_nss_n_in;
      nss_s2_reg <= nss_s1_reg;
      nss_s3_reg <= nss_s2_reg;
      mosi_s1_reg <= spi_mosi_in;
      mosi_s2_reg <= mosi_s1_reg;
    end
  end

  wire sel = ~nss_s2_reg;
  wire nss_fall = ~nss_s2_reg & nss_s3_reg;
  wire nss_rise = nss_s2_reg & ~nss_s3_reg;
  // Mode 0: sample on the rising edge, shift out on the falling one.
  wire sck_rise = sel & sck_s2_reg & ~sck_s3_reg;
  wire sck_fall = sel & ~sck_s2_reg & sck_s3_reg;

  // ----------------------------------------------------------------
  // Serial shifters
  // ----------------------------------------------------------------
  reg [7:0] rx_shift_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] tx_shift_reg;
  reg [2:0] tx_idx_reg;
  reg resp_frame_reg;
  reg resp_pend_reg;
  reg [31:0] resp_word_reg;
  reg push_vld_reg;
  reg [`SHC_FIFO_W-1:0] push_data_reg;
  reg miso_reg, miso_oe_reg, pullup_reg;
  reg [7:0] tx_next;

  always @*
  begin
    case (tx_idx_reg)
      3'h0: tx_next = resp_word_reg[7:0];
      3'h1: tx_next = resp_word_reg[15:8];
      3'h2: tx_next = resp_word_reg[23:16];
      3'h3: tx_next = resp_word_reg[31:24];
      default: tx_next = 8'h00;
    endcase
  end

  wire byte_done = sck_rise & (bit_cnt_reg == 3'h7);
  wire fifo_in_ready;

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rx_shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_idx_reg <= 3'h0;
      resp_frame_reg <= 1'b0;
      push_vld_reg <= 1'b0;
      push_data_reg <= {`SHC_FIFO_W{1'b0}};
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      pullup_reg <= 1'b0;
    end
    else
    begin
      push_vld_reg <= 1'b0;
      if (nss_fall)
      begin
        // A pending response turns this whole frame into a read-out.
        resp_frame_reg <= resp_pend_reg;
        bit_cnt_reg <= 3'h0;
        tx_shift_reg <= resp_word_reg[7:0];
        tx_idx_reg <= 3'h1;
      end
      if (sck_rise)
      begin
        rx_shift_reg <= {rx_shift_reg[6:0], mosi_s2_reg};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
      if (sck_fall)
      begin
        if (bit_cnt_reg == 3'h0)
        begin
          tx_shift_reg <= tx_next;
          if (tx_idx_reg != 3'h4)
          begin
            tx_idx_reg <= tx_idx_reg + 3'h1;
          end
        end
        else
        begin
          tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end
      end
      // Filler bytes of a read-out frame are dropped here.
      if (byte_done & ~resp_frame_reg)
      begin
        push_vld_reg <= 1'b1;
        push_data_reg <= {1'b0, rx_shift_reg[6:0], mosi_s2_reg};
      end
      else if (nss_rise & ~resp_frame_reg)
      begin
        // End marker; bit 0 flags a frame cut inside a byte.
        push_vld_reg <= 1'b1;
        push_data_reg <= {1'b1, 7'h00, (bit_cnt_reg != 3'h0)};
      end
      miso_oe_reg <= sel;
      miso_reg <= sel & resp_frame_reg & tx_shift_reg[7];
      pullup_reg <= miso_pullup_cfg_in;
    end
  end

  assign spi_miso_out = miso_reg;
  assign spi_miso_oe_out = miso_oe_reg;
  assign miso_pullup_en_out = pullup_reg;

  // ----------------------------------------------------------------
  // Receive store
  // ----------------------------------------------------------------
  wire fifo_out_valid;
  wire [`SHC_FIFO_W-1:0] fifo_out_data;
  reg [3:0] state_reg;

  // Lets the host clock bytes in while the engine is still executing.
  shc_fifo #(
    .WIDTH(`SHC_FIFO_W),
    .DEPTH(`SHC_FIFO_D),
    .AW(`SHC_FIFO_AW)
  ) u_fifo (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(push_vld_reg),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_data_reg),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(state_reg == ST_IDLE),
    .out_data_out(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------
  reg [7:0] opc_reg;
  reg [7:0] addr_reg;
  reg [31:0] data_reg;
  reg [8:0] cnt_reg;
  reg cut_reg;
  wire [31:0] rd_data;

  wire opc_write = (opc_reg == `SHC_OPC_WRITE);
  wire opc_read = (opc_reg == `SHC_OPC_READ);
  wire opc_mask = (opc_reg == `SHC_OPC_OR) | (opc_reg == `SHC_OPC_AND);
  wire addr_ok = (addr_reg[7:`SHC_REG_AW] == {(8-`SHC_REG_AW){1'b0}});
  wire len_ok = ~cut_reg & (cnt_reg <= `SHC_LEN_MAX) &
    (opc_read ? (cnt_reg == `SHC_LEN_READ) :
    (cnt_reg == `SHC_LEN_WRITE));
  wire cmd_ok = (opc_write | opc_read | opc_mask) & addr_ok & len_ok;

  wire ram_we = ((state_reg == ST_EXEC) & cmd_ok & opc_write) |
    ((state_reg == ST_RD) & opc_mask);
  wire ram_re = (state_reg == ST_EXEC) & cmd_ok & ~opc_write;
  wire [31:0] ram_wdata = (state_reg == ST_EXEC) ? data_reg :
    ((opc_reg == `SHC_OPC_OR) ? (rd_data | data_reg) :
    (rd_data & data_reg));

  shc_regbank #(
    .AW(`SHC_REG_AW),
    .DW(`SHC_REG_DW)
  ) u_regs (
    .clock_in(clock_in),
    .wr_en_in(ram_we),
    .rd_en_in(ram_re),
    .addr_in(addr_reg[`SHC_REG_AW-1:0]),
    .wr_data_in(ram_wdata),
    .rd_data_out(rd_data)
  );

  reg fault_set, done_set;

  always @*
  begin
    fault_set = (state_reg == ST_EXEC) & ~cmd_ok;
    done_set = ((state_reg == ST_EXEC) & cmd_ok & opc_write) |
      (state_reg == ST_RD);
  end

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= ST_IDLE;
      opc_reg <= 8'h00;
      addr_reg <= 8'h00;
      data_reg <= 32'h00000000;
      cnt_reg <= 9'h000;
      cut_reg <= 1'b0;
      resp_pend_reg <= 1'b0;
      resp_word_reg <= 32'h00000000;
    end
    else
    begin
      if (nss_rise & resp_frame_reg)
      begin
        resp_pend_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE:
        begin
          if (fifo_out_valid & fifo_out_data[`SHC_MARK_BIT])
          begin
            cut_reg <= fifo_out_data[0];
            if ((cnt_reg != 9'h000) | fifo_out_data[0])
            begin
              state_reg <= ST_EXEC;
            end
          end
          else if (fifo_out_valid)
          begin
            if (cnt_reg == 9'h000)
            begin
              opc_reg <= fifo_out_data[7:0];
            end
            else if (cnt_reg == 9'h001)
            begin
              addr_reg <= fifo_out_data[7:0];
            end
            else
            begin
              // Least significant byte arrives first.
              data_reg <= {fifo_out_data[7:0], data_reg[31:8]};
            end
            if (cnt_reg != `SHC_CNT_SAT)
            begin
              cnt_reg <= cnt_reg + 9'h001;
            end
          end
        end
        ST_EXEC:
        begin
          cnt_reg <= 9'h000;
          if (cmd_ok & ~opc_write)
          begin
            state_reg <= ST_RD;
          end
          else
          begin
            state_reg <= ST_IDLE;
          end
        end
        ST_RD:
        begin
          state_reg <= ST_IDLE;
          if (opc_read)
          begin
            resp_word_reg <= rd_data;
            resp_pend_reg <= 1'b1;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Busy, status flags and interrupt pin
  // ----------------------------------------------------------------
  reg busy_reg;
  reg irq_reg;
  reg [`SHC_NFLAGS-1:0] status_reg;
  reg [`SHC_NFLAGS-1:0] status_next;
  reg [`SHC_NFLAGS-1:0] set_v;
  reg [`SHC_NFLAGS-1:0] clr_v;

  always @*
  begin
    set_v = {`SHC_NFLAGS{1'b0}};
    set_v[`SHC_FLAG_FAULT] = fault_set;
    set_v[`SHC_FLAG_OVF] = push_vld_reg & ~fifo_in_ready;
    set_v[`SHC_FLAG_DONE] = done_set;
    if (clear_on_read_cfg_in)
    begin
      clr_v = status_read_in ? {`SHC_NFLAGS{1'b1}} : {`SHC_NFLAGS{1'b0}};
    end
    else
    begin
      clr_v = irq_clear_in;
    end
    // A flag raised in the clearing cycle survives the clear.
    status_next = set_v | (status_reg & ~clr_v);
  end

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      status_reg <= {`SHC_NFLAGS{1'b0}};
      irq_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      if (|(status_next & irq_enable_in))
      begin
        irq_reg <= irq_active_high_cfg_in;
      end
      else
      begin
        irq_reg <= ~irq_active_high_cfg_in;
      end
      // Held over frame end until the engine has drained its work.
      busy_reg <= sel | nss_rise | push_vld_reg | fifo_out_valid |
        (state_reg != ST_IDLE);
    end
  end

  assign busy_out = busy_reg;
  assign irq_out = irq_reg;
  assign irq_status_out = status_reg;

endmodule // shc_host_port

`default_nettype wire

// file: shc_host_port_asserts.sv
// Concurrent checks on the ports of the SPI host command port.
`default_nettype none
`include "shc_regs.vh"
module shc_host_port_chk (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic spi_sck_in,
  input wire logic spi_nss_n_in,
  input wire logic spi_mosi_in,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe_out,
  input wire logic miso_pullup_cfg_in,
  input wire logic clear_on_read_cfg_in,
  input wire logic irq_active_high_cfg_in,
  input wire logic [`SHC_NFLAGS-1:0] irq_enable_in,
  input wire logic [`SHC_NFLAGS-1:0] irq_clear_in,
  input wire logic status_read_in,
  input wire logic miso_pullup_en_out,
  input wire logic busy_out,
  input wire logic irq_out,
  input wire logic [`SHC_NFLAGS-1:0] irq_status_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Five samples cover the two-flop synchroniser lag on the select pin.
  property p_oe_off; spi_nss_n_in [*5] |-> !spi_miso_oe_out; endproperty
  property p_oe_on; !spi_nss_n_in [*5] |-> spi_miso_oe_out; endproperty
  property p_busy_frm; !spi_nss_n_in [*5] |-> busy_out; endproperty
  property p_busy_rel; $rose(spi_nss_n_in) |-> ##[1:80] !busy_out;
  endproperty
  property p_irq;
    !$past(sys_rst_in) |-> irq_out == ((|(irq_status_out &
      $past(irq_enable_in))) ~^ $past(irq_active_high_cfg_in));
  endproperty
  // A flag raised in the clearing cycle rightly survives the clear, so the
  // clear checks only look while busy is low and the engine raises nothing.
  property p_clr_rd;
    clear_on_read_cfg_in && status_read_in && !busy_out |=>
      irq_status_out == 3'h0;
  endproperty
  property p_clr_mask;
    !clear_on_read_cfg_in && |irq_clear_in && !busy_out |=>
      (irq_status_out & $past(irq_clear_in)) == 3'h0;
  endproperty
  property p_keep_rd;
    clear_on_read_cfg_in && !status_read_in |=>
      (irq_status_out & $past(irq_status_out)) == $past(irq_status_out);
  endproperty
  property p_sticky;
    !clear_on_read_cfg_in && irq_clear_in == 3'h0 |=>
      (irq_status_out & $past(irq_status_out)) == $past(irq_status_out);
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data out enabled while deselected");
  a_oe_on: assert property (p_oe_on)
    else $error("data out not enabled while selected");
  a_busy_frm: assert property (p_busy_frm)
    else $error("busy low during a frame");
  a_busy_rel: assert property (p_busy_rel)
    else $error("busy not released after a frame");
  a_irq: assert property (p_irq)
    else $error("irq level differs from enabled flags");
  a_clr_rd: assert property (p_clr_rd)
    else $error("status read left flags set");
  a_clr_mask: assert property (p_clr_mask)
    else $error("clear mask left flags set");
  a_keep_rd: assert property (p_keep_rd)
    else $error("flag dropped without a status read");
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a clear");
  c_fault: cover property (irq_status_out[0] && irq_out);
  c_resp: cover property (!spi_nss_n_in && spi_miso_out);
  c_rd: cover property (status_read_in && |irq_status_out);
endmodule // shc_host_port_chk
bind shc_host_port shc_host_port_chk chk_u (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .spi_sck_in(spi_sck_in),
  .spi_nss_n_in(spi_nss_n_in), .spi_mosi_in(spi_mosi_in),
  .spi_miso_out(spi_miso_out), .spi_miso_oe_out(spi_miso_oe_out),
  .miso_pullup_cfg_in(miso_pullup_cfg_in),
  .clear_on_read_cfg_in(clear_on_read_cfg_in),
  .irq_active_high_cfg_in(irq_active_high_cfg_in),
  .irq_enable_in(irq_enable_in), .irq_clear_in(irq_clear_in),
  .status_read_in(status_read_in), .miso_pullup_en_out(miso_pullup_en_out),
  .busy_out(busy_out), .irq_out(irq_out), .irq_status_out(irq_status_out));
`default_nettype wire

// file: shc_spi_host.sv
// Behavioural SPI master standing in for the host controller.
`default_nettype none
module shc_spi_host (
  output var logic sck_out,
  output var logic nss_n_out,
  output var logic mosi_out,
  input wire logic miso_in,
  input wire logic miso_oe_in,
  input wire logic pullup_en_in
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF = 24.0;
  int gap = 0;
  logic last_bit = 1'b0;
  // Without the pull-up a floating line shows the inverse of its last value, not a stale copy.
  wire logic pin = miso_oe_in ? miso_in :
    (pullup_en_in | ~last_bit);
  initial
  begin
    sck_out = 1'b0;
    nss_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  always @*
    if (miso_oe_in)
      last_bit = miso_in;
  // ----------------------------------------------------------------
  // Frame tasks
  // ----------------------------------------------------------------
  task automatic start;
    #1.3;
    nss_n_out = 1'b0;
    #30;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi_out = tx[i];
      #HALF;
      sck_out = 1'b1;
      rx[i] = pin;
      #HALF;
      sck_out = 1'b0;
    end
    #(gap);
  endtask
  task automatic stop;
    #HALF;
    nss_n_out = 1'b1;
    mosi_out = ~mosi_out;
  endtask
endmodule // shc_spi_host
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the SPI host command port.
`default_nettype none
`include "shc_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic pull_cfg = 1'b1;
  logic cor_cfg = 1'b0;
  logic ah_cfg = 1'b1;
  logic rd_pulse = 1'b0;
  logic [2:0] irq_en = 3'h7;
  logic [2:0] irq_clr = 3'h0;
  wire logic sck, nss_n, mosi, miso, oe, pull_en, busy, irq;
  wire logic [2:0] stat;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] rx_q[$];
  logic [7:0] fop[4] = '{8'h03, 8'h00, 8'h00, 8'h04};
  logic [7:0] fad[4] = '{8'h05, 8'h40, 8'h05, 8'h05};
  int flen[4] = '{6, 6, 5, 3};
  shc_host_port dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .spi_sck_in(sck), .spi_nss_n_in(nss_n), .spi_mosi_in(mosi),
    .spi_miso_out(miso), .spi_miso_oe_out(oe), .miso_pullup_cfg_in(pull_cfg),
    .clear_on_read_cfg_in(cor_cfg), .irq_active_high_cfg_in(ah_cfg),
    .irq_enable_in(irq_en), .irq_clear_in(irq_clr),
    .status_read_in(rd_pulse), .miso_pullup_en_out(pull_en),
    .busy_out(busy), .irq_out(irq), .irq_status_out(stat));
  shc_spi_host host_u (.sck_out(sck), .nss_n_out(nss_n), .mosi_out(mosi),
    .miso_in(miso), .miso_oe_in(oe), .pullup_en_in(pull_en));
  initial
  begin
    forever #2.5 clock_in = ~clock_in;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic frame(input logic [7:0] tx[$]);
    logic [7:0] b;
    int n;
    rx_q = {};
    host_u.start();
    foreach (tx[i])
    begin
      host_u.xfer(tx[i], b);
      rx_q.push_back(b);
    end
    for (n = 0; busy !== 1'b1 && n < 20; n++)
      @(posedge clock_in);
    host_u.stop();
    repeat (4) @(posedge clock_in);
    for (n = 0; busy !== 1'b0 && n < 200; n++)
      @(posedge clock_in);
    check({31'h0, busy}, 32'h0);
    repeat (2) @(posedge clock_in);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] a,
                     input logic [31:0] d, input int len);
    logic [7:0] q[$];
    logic [7:0] acc;
    q = '{op, a, d[7:0], d[15:8], d[23:16], d[31:24]};
    while (q.size() > len)
      void'(q.pop_back());
    frame(q);
    acc = 8'h00;
    foreach (rx_q[i])
      acc = acc | rx_q[i];
    check({24'h0, acc}, 32'h0);
  endtask
  task automatic rdreg(input logic [7:0] a, input logic [31:0] exp);
    cmd(`SHC_OPC_READ, a, 32'h0, 2);
    frame('{8'hFF, 8'hFF, 8'hFF, 8'hFF});
    check({rx_q[3], rx_q[2], rx_q[1], rx_q[0]}, exp);
  endtask
  task automatic pulse(input logic [2:0] m, input logic r);
    @(posedge clock_in);
    irq_clr <= m;
    rd_pulse <= r;
    @(posedge clock_in);
    irq_clr <= 3'h0;
    rd_pulse <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    #400000;
    errors++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    check({pull_en, busy, oe, irq, stat}, 7'h40);
    $display("test reset done");
    cmd(`SHC_OPC_WRITE, 8'h05, 32'h12345678, 6);
    check({irq, stat}, 4'hC);
    pulse(3'h7, 1'b0);
    rdreg(8'h05, 32'h12345678);
    cmd(`SHC_OPC_OR, 8'h05, 32'h0F0F0000, 6);
    rdreg(8'h05, 32'h1F3F5678);
    cmd(`SHC_OPC_AND, 8'h05, 32'hFF00FF0F, 6);
    rdreg(8'h05, 32'h1F005608);
    host_u.gap = 100;
    cmd(`SHC_OPC_WRITE, 8'h00, 32'hA5C30F96, 6);
    cmd(`SHC_OPC_WRITE, 8'h3F, 32'h0BAD003F, 6);
    host_u.gap = 0;
    rdreg(8'h00, 32'hA5C30F96);
    rdreg(8'h3F, 32'h0BAD003F);
    $display("test commands done");
    for (int i = 0; i < 4; i++)
    begin
      pulse(3'h7, 1'b0);
      cmd(fop[i], fad[i], 32'hDEADBEEF, flen[i]);
      check({irq, stat[0]}, 2'h3);
    end
    rdreg(8'h05, 32'h1F005608);
    rdreg(8'h00, 32'hA5C30F96);
    $display("test faults done");
    pulse(3'h7, 1'b0);
    irq_en <= 3'h0;
    cmd(8'h03, 8'h05, 32'h0, 6);
    check({irq, stat[0]}, 2'h1);
    irq_en <= 3'h1;
    repeat (3) @(posedge clock_in);
    check({30'h0, irq, stat[0]}, 32'h3);
    cor_cfg <= 1'b1;
    pulse(3'h7, 1'b0);
    check({irq, stat[0]}, 2'h3);
    pulse(3'h0, 1'b1);
    check({irq, stat}, 4'h0);
    ah_cfg <= 1'b0;
    repeat (3) @(posedge clock_in);
    check({31'h0, irq}, 32'h1);
    cmd(8'h03, 8'h05, 32'h0, 6);
    check({irq, stat[0]}, 2'h1);
    pull_cfg <= 1'b0;
    repeat (3) @(posedge clock_in);
    check({31'h0, pull_en}, 32'h0);
    pull_cfg <= 1'b1;
    repeat (3) @(posedge clock_in);
    check({31'h0, pull_en}, 32'h1);
    $display("test interrupts done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
